// >>> rtl/bfs_pkg.sv
// Purpose: shared constants and types for the bus fault status frame block
// Assumes: one clock domain, register port with one-cycle read latency
// Notes: word layout and register offsets live here only
package bfs_pkg;
    // ****************************************************************
    // fault status word layout
    // ****************************************************************
    localparam int FSW_W = 16;
    localparam int BIT_CLASS = 15;
    localparam int BIT_MOVE = 14;
    localparam int BIT_STEP = 12;
    localparam int BIT_BK1 = 11;
    localparam int BIT_BK0 = 10;
    localparam int BIT_RERUN = 9;
    localparam int BIT_ATOM = 8;
    localparam int BIT_PREF = 7;
    localparam int BIT_READ = 6;
    localparam int BIT_LONG = 5;
    localparam int SIZ_HI = 4;
    localparam int SIZ_LO = 3;
    localparam int SPC_HI = 2;
    localparam int SPC_LO = 0;
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [FSW_W-1:0] FSW_RESET = 16'h0000;
    localparam logic [FSW_W-1:0] FSW_USED = 16'hdfff;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_FSW = 4'h0;
    localparam logic [ADDR_W-1:0] REG_PC = 4'h1;
    localparam logic [ADDR_W-1:0] REG_SR = 4'h2;
    localparam logic [ADDR_W-1:0] REG_ADDR = 4'h3;
    localparam logic [ADDR_W-1:0] REG_DATA = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STAT = 4'h5;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;

    typedef enum logic [1:0] {
        FT_RELEASED, FT_EXCEPTION, FT_MOVE, FT_OTHER
    } bfs_fault_t;

    // description of the faulted bus cycle from the bus controller
    typedef struct packed {
        logic is_read;
        logic is_prefetch;
        logic is_atomic;
        logic is_released;
        logic in_exception;
        logic in_move_xfer;
        logic move_refetch;
        logic long_orig;
        logic [1:0] remaining;
        logic [2:0] space;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bfs_cycle_t;

    // pending exceptions and context at the fault
    typedef struct packed {
        logic step;
        logic bk_ext;
        logic bk_int;
        logic [31:0] next_pc;
        logic [15:0] sr;
    } bfs_ctx_t;

    // cycle rebuilt for the bus controller on return
    typedef struct packed {
        logic is_read;
        logic [1:0] remaining;
        logic [2:0] space;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bfs_rerun_t;
endpackage

// >>> rtl/bfs_fault_unit.sv
// Purpose: sorts bus faults, builds and holds the fault status frame
// Assumes: bus controller and sequencer share mclk, inputs are synchronous
// Notes: the frame registers are software visible over the register port
//
// Notes on behaviour
// RULE1 - frame class 0 for operand or prefetch fault, 1 in exception work
// RULE2 - block move flag in operand phase; refetch fault sets move and prefetch
// RULE3 - step flag set when trace pending at fault processing
// RULE4 - external breakpoint in channel 1, internal in channel 0, always stacked
// RULE5 - rerun flag only for released write; return reruns if stacked flag set
// RULE6 - handler that completes the write clears stacked rerun flag first
// RULE7 - on rerun return reload read flag, size and space code
// RULE8 - atomic flag for either part of read-modify-write, ignored on unstack
// RULE9 - prefetch flag 0 for operand fault, 1 for prefetch, ignored on unstack
// RULE10 - read flag 1 for prefetch or read, 0 for operand write
// RULE11 - long flag set for long original operand, ignored on unstack
// RULE12 - size field 00 long, 01 byte, 10 word, 11 reserved
// RULE13 - space code field copies the three function code outputs
// RULE14 - unused word bits written zero and ignored on unstack
// RULE15 - each fault sorted as released, exception, block move or other
// RULE16 - released write fault taken at next instruction boundary with next pc
// RULE17 - operand access with released fault pending aborts, fault taken now
// RULE18 - released write word has class, move, atomic, prefetch, read zero
// RULE19 - released write stacks next pc, status, address and write data
// RULE20 - prefetch, read, atomic, peripheral move are restartable; last write released
// RULE21 - restartable fault taken at once, aborts, restores address registers
// RULE22 - restartable fault always stacks step flag zero
// RULE23 - word bits: 15 class, 14 move, 12 step, 11..10 bkpt, 9 rerun, low fields
`timescale 1ns/100ps
module bfs_fault_unit
    import bfs_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic bus_fault_input,
    input wire bfs_pkg::bfs_cycle_t cycle,
    input wire bfs_pkg::bfs_ctx_t ctx,
    input wire logic insn_boundary,
    input wire logic operand_access,
    input wire logic exception_return,
    input wire logic [bfs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic take_fault,
    output logic abort_insn,
    output logic restore_ea_regs,
    output bfs_pkg::bfs_fault_t fault_type,
    output logic rerun_start,
    output bfs_pkg::bfs_rerun_t rerun_cycle
);
    import bfs_pkg::*;

    // ****************************************************************
    // classification
    // ****************************************************************
    // sort the faulting cycle; exception work outranks everything
    function automatic bfs_fault_t classify(input bfs_cycle_t c);
        if (c.in_exception) begin
            return FT_EXCEPTION;
        end else if (c.is_released && !c.is_read) begin
            return FT_RELEASED;
        end else if (c.in_move_xfer) begin
            return FT_MOVE;
        end else begin
            return FT_OTHER;
        end
    endfunction

    // assemble the status word; unused bit 13 stays zero; RULE23
    function automatic logic [FSW_W-1:0] build_word(input bfs_fault_t t,
        input bfs_cycle_t c, input bfs_ctx_t x);
        logic [FSW_W-1:0] w;
        w = FSW_RESET; // RULE14
        w[BIT_CLASS] = (t == FT_EXCEPTION); // RULE1
        w[BIT_MOVE] = (t == FT_MOVE) || c.move_refetch; // RULE2
        w[BIT_STEP] = x.step && (t != FT_OTHER); // RULE3 RULE22
        w[BIT_BK1] = x.bk_ext; // RULE4
        w[BIT_BK0] = x.bk_int; // RULE4
        w[BIT_RERUN] = (t == FT_RELEASED); // RULE5
        w[BIT_ATOM] = c.is_atomic && (t == FT_OTHER); // RULE8 RULE18
        w[BIT_PREF] = (c.is_prefetch || c.move_refetch)
            && (t != FT_RELEASED); // RULE9 RULE2
        w[BIT_READ] = (c.is_read || c.is_prefetch)
            && (t != FT_RELEASED); // RULE10 RULE18
        w[BIT_LONG] = c.long_orig; // RULE11
        w[SIZ_HI:SIZ_LO] = c.remaining; // RULE12
        w[SPC_HI:SPC_LO] = c.space; // RULE13
        return w;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    logic [FSW_W-1:0] fsw;
    logic [31:0] st_pc;
    logic [15:0] st_sr;
    logic [31:0] st_addr;
    logic [31:0] st_data;
    logic released_pending;
    logic [FSW_W-1:0] held_word;
    bfs_fault_t held_type;
    bfs_fault_t now_type;
    logic now_fault;
    logic fire_released;

    assign now_type = classify(cycle); // RULE15 RULE20
    assign now_fault = bus_fault_input && (now_type != FT_RELEASED);
    // deferred write fault fires at a boundary or on an operand access
    assign fire_released = released_pending
        && (insn_boundary || operand_access); // RULE16 RULE17

    // hold a released write fault until the sequencer reaches a safe point
    always_ff @(posedge mclk) begin
        if (reset) begin
            released_pending <= 1'b0;
            held_word <= FSW_RESET;
            held_type <= FT_OTHER;
        end else if (bus_fault_input && now_type == FT_RELEASED) begin
            released_pending <= 1'b1; // RULE16
            held_word <= build_word(now_type, cycle, ctx); // RULE18
            held_type <= now_type;
        end else if (fire_released) begin
            released_pending <= 1'b0;
        end
    end

    // address and data of the write are latched with the fault itself
    always_ff @(posedge mclk) begin
        if (reset) begin
            st_addr <= ZERO32;
            st_data <= ZERO32;
        end else if (reg_write && reg_addr == REG_ADDR) begin
            st_addr <= reg_wdata;
        end else if (reg_write && reg_addr == REG_DATA) begin
            st_data <= reg_wdata;
        end else if (bus_fault_input) begin
            st_addr <= cycle.addr; // RULE19
            st_data <= cycle.wdata; // RULE19
        end
    end

    // status word and context; a hardware fault wins over a software write
    always_ff @(posedge mclk) begin
        if (reset) begin
            fsw <= FSW_RESET;
            st_pc <= ZERO32;
            st_sr <= 16'h0000;
        end else if (fire_released) begin
            // step and breakpoints are sampled now, at the boundary or operand access
            fsw <= held_word | {3'h0, ctx.step, ctx.bk_ext, ctx.bk_int,
                10'h000}; // RULE16 RULE4
            st_pc <= ctx.next_pc; // RULE19 RULE16
            st_sr <= ctx.sr; // RULE19
        end else if (now_fault) begin
            fsw <= build_word(now_type, cycle, ctx); // RULE21
            st_pc <= ctx.next_pc;
            st_sr <= ctx.sr;
        end else if (reg_write && reg_addr == REG_FSW) begin
            fsw <= reg_wdata[FSW_W-1:0] & FSW_USED; // RULE6 RULE14
        end else if (reg_write && reg_addr == REG_PC) begin
            st_pc <= reg_wdata;
        end else if (reg_write && reg_addr == REG_SR) begin
            st_sr <= reg_wdata[15:0];
        end
    end

    // exception request towards the sequencer, one cycle pulse
    always_ff @(posedge mclk) begin
        if (reset) begin
            take_fault <= 1'b0;
            abort_insn <= 1'b0;
            restore_ea_regs <= 1'b0;
            fault_type <= FT_OTHER;
        end else begin
            take_fault <= now_fault || fire_released; // RULE21
            // boundary entry aborts nothing; access entry aborts the user
            abort_insn <= now_fault
                || (fire_released && operand_access); // RULE17 RULE21
            restore_ea_regs <= now_fault
                && (now_type == FT_OTHER); // RULE21
            // type of the last fault taken; idle cycle lines carry no type
            if (fire_released) begin
                fault_type <= held_type;
            end else if (now_fault) begin
                fault_type <= now_type; // RULE15
            end
        end
    end

    // ****************************************************************
    // exception return
    // ****************************************************************
    // only rerun bit and cycle fields are read back; others are ignored
    always_ff @(posedge mclk) begin
        if (reset) begin
            rerun_start <= 1'b0;
            rerun_cycle <= '0;
        end else begin
            rerun_start <= exception_return && fsw[BIT_RERUN]; // RULE5
            if (exception_return && fsw[BIT_RERUN]) begin
                rerun_cycle.is_read <= fsw[BIT_READ]; // RULE7
                rerun_cycle.remaining <= fsw[SIZ_HI:SIZ_LO]; // RULE7
                rerun_cycle.space <= fsw[SPC_HI:SPC_LO]; // RULE7
                rerun_cycle.addr <= st_addr;
                rerun_cycle.wdata <= st_data;
            end
        end
    end

    // ****************************************************************
    // register port
    // ****************************************************************
    // read data valid the cycle after the strobe, zero elsewhere
    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= ZERO32;
        end else if (reg_read) begin
            unique case (reg_addr)
                REG_FSW: reg_rdata <= {16'h0000, fsw};
                REG_PC: reg_rdata <= st_pc;
                REG_SR: reg_rdata <= {16'h0000, st_sr};
                REG_ADDR: reg_rdata <= st_addr;
                REG_DATA: reg_rdata <= st_data;
                REG_STAT: reg_rdata <= {29'h0, fault_type, released_pending};
                default: reg_rdata <= ZERO32;
            endcase
        end else begin
            reg_rdata <= ZERO32;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_CLASS_BIT: assert property (@(posedge mclk) disable iff (reset)
        now_fault && !fire_released |=>
        fsw[BIT_CLASS] == (fault_type == FT_EXCEPTION)) // RULE1
        else $error("class bit disagrees with fault type");
    AST_BK_STACKED: assert property (@(posedge mclk) disable iff (reset)
        now_fault && !fire_released |=>
        fsw[BIT_BK1] == $past(ctx.bk_ext) && fsw[BIT_BK0] == $past(ctx.bk_int))
        // RULE4
        else $error("breakpoint bits not stacked");
    AST_RERUN_ONLY_REL: assert property (@(posedge mclk) disable iff (reset)
        take_fault |-> fsw[BIT_RERUN] == (fault_type == FT_RELEASED)) // RULE5
        else $error("rerun flag on wrong fault type");
    AST_RERUN_RET: assert property (@(posedge mclk) disable iff (reset)
        exception_return && fsw[BIT_RERUN] |=> rerun_start
        && rerun_cycle.space == $past(fsw[SPC_HI:SPC_LO])) // RULE7
        else $error("rerun not started with stacked fields");
    AST_NO_RERUN: assert property (@(posedge mclk) disable iff (reset)
        !fsw[BIT_RERUN] |=> !rerun_start) // RULE5
        else $error("rerun without stacked flag");
    AST_UNUSED_ZERO: assert property (@(posedge mclk) disable iff (reset)
        fsw[13] == 1'b0) // RULE14
        else $error("unused bit set");
    AST_STEP_CLEAR: assert property (@(posedge mclk) disable iff (reset)
        take_fault && fault_type == FT_OTHER |-> !fsw[BIT_STEP]) // RULE22
        else $error("step flag on restartable fault");
    AST_REL_DEFER: assert property (@(posedge mclk) disable iff (reset)
        released_pending && !insn_boundary && !operand_access && !now_fault
        |=> !take_fault) // RULE16
        else $error("released fault taken early");
    AST_REL_ZEROS: assert property (@(posedge mclk) disable iff (reset)
        take_fault && fault_type == FT_RELEASED |->
        fsw[BIT_READ:BIT_PREF] == 2'h0 && !fsw[BIT_ATOM]) // RULE18
        else $error("released word flags wrong");
    AST_SPACE: assert property (@(posedge mclk) disable iff (reset)
        now_fault && !fire_released |=>
        fsw[SPC_HI:SPC_LO] == $past(cycle.space)) // RULE13
        else $error("space code not copied");
    AST_ABORT_ACCESS: assert property (@(posedge mclk) disable iff (reset)
        fire_released && operand_access |=> take_fault && abort_insn) // RULE17
        else $error("access with pending write fault not aborted");
    AST_BOUNDARY_NO_ABORT: assert property (@(posedge mclk)
        disable iff (reset)
        fire_released && !operand_access && !now_fault |=> !abort_insn)
        // RULE16
        else $error("boundary entry aborted an instruction");
    AST_RESTORE_OTHER: assert property (@(posedge mclk) disable iff (reset)
        restore_ea_regs |-> take_fault && fault_type == FT_OTHER) // RULE21
        else $error("address registers restored on wrong fault type");
    COV_ABORT: cover property (@(posedge mclk)
        take_fault && abort_insn && fault_type == FT_RELEASED);
    COV_REL: cover property (@(posedge mclk)
        take_fault && fault_type == FT_RELEASED);
    COV_MOVE: cover property (@(posedge mclk)
        take_fault && fault_type == FT_MOVE);
    COV_EXC: cover property (@(posedge mclk)
        take_fault && fault_type == FT_EXCEPTION);
    COV_RERUN: cover property (@(posedge mclk) rerun_start);
endmodule

// >>> testbench/bfs_host_model.sv
// Purpose: host model: bus controller and fault handler software
// Assumes: requests change just after the rising edge of mclk
// Notes: fault lines show the inverse once the fault pulse is gone
`timescale 1ns/100ps
module bfs_host_model
    import bfs_pkg::*;
(
    input wire logic mclk,
    output logic bus_fault_input,
    output bfs_pkg::bfs_cycle_t cycle,
    output bfs_pkg::bfs_ctx_t ctx,
    output logic insn_boundary,
    output logic operand_access,
    output logic exception_return,
    output logic [bfs_pkg::ADDR_W-1:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [31:0] reg_rdata
);
    // ****************************************************************
    // idle state at time zero
    // ****************************************************************
    initial begin
        {bus_fault_input, insn_boundary, operand_access} = 3'h0;
        {exception_return, reg_write, reg_read} = 3'h0;
        cycle = '0;
        ctx = '0;
        reg_addr = '0;
        reg_wdata = '0;
    end

    // ****************************************************************
    // request tasks
    // ****************************************************************
    // one-cycle fault pulse; stale cycle lines inverted, ctx left as driven
    task automatic fault(input bfs_cycle_t c, input bfs_ctx_t x);
        @(posedge mclk);
        bus_fault_input <= 1'b1;
        cycle <= c;
        ctx <= x;
        @(posedge mclk);
        bus_fault_input <= 1'b0;
        cycle <= ~c;
    endtask

    // 0 boundary, 1 operand access, 2 exception return
    task automatic strobe(input int which, input bfs_ctx_t x);
        @(posedge mclk);
        ctx <= x;
        insn_boundary <= (which == 0);
        operand_access <= (which == 1);
        exception_return <= (which == 2);
        @(posedge mclk);
        {insn_boundary, operand_access, exception_return} <= 3'h0;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_write <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_read <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask

    // handler finished the write itself: drop rerun before return
    task automatic handler_done();
        logic [31:0] w;
        reg_rd(REG_FSW, w);
        w[BIT_RERUN] = 1'b0;
        reg_wr(REG_FSW, w);
        strobe(2, '0);
    endtask
endmodule

// >>> testbench/bus_fault_status_frame_bench.sv
// Purpose: self-checking bench for the fault status frame unit
// Assumes: host model owns every input of the unit except clock, reset
// Notes: ends through conclude on finish or on cycle ceiling
`timescale 1ns/100ps
module bus_fault_status_frame_bench;
    import bfs_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic bus_fault_input, insn_boundary, operand_access, exception_return;
    logic reg_write, reg_read, take_fault, abort_insn, restore_ea_regs;
    logic rerun_start;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    bfs_cycle_t cycle;
    bfs_ctx_t ctx;
    bfs_fault_t fault_type;
    bfs_rerun_t rerun_cycle;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic seen, ab, rs;
    logic [1:0] ft;
    bfs_rerun_t rc;

    bfs_fault_unit uut(.mclk(mclk), .reset(reset),
        .bus_fault_input(bus_fault_input), .cycle(cycle), .ctx(ctx),
        .insn_boundary(insn_boundary), .operand_access(operand_access),
        .exception_return(exception_return), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .take_fault(take_fault),
        .abort_insn(abort_insn), .restore_ea_regs(restore_ea_regs),
        .fault_type(fault_type), .rerun_start(rerun_start),
        .rerun_cycle(rerun_cycle));
    bfs_host_model host(.mclk(mclk), .bus_fault_input(bus_fault_input),
        .cycle(cycle), .ctx(ctx), .insn_boundary(insn_boundary),
        .operand_access(operand_access),
        .exception_return(exception_return), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata));

    // ****************************************************************
    // clock, ceiling and helpers
    // ****************************************************************
    always #50 mclk = ~mclk;
    // a hang costs a mismatch, then the normal report
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    function automatic bfs_cycle_t mk(input logic [7:0] f,
        input logic [1:0] rem, input logic [2:0] sp);
        mk = {f, rem, sp, 32'h1234_5678, 32'hcafe_0001};
    endfunction

    function automatic bfs_ctx_t mx(input logic [2:0] p);
        mx = {p, 32'h0000_0100, 16'h2700};
    endfunction

    // bounded wait for the fault to be taken, capture its qualifiers
    task automatic wait_take();
        seen = 1'b0;
        for (int i = 0; i < 4 && !seen; i++) begin
            @(negedge mclk);
            seen = (take_fault === 1'b1);
            {ab, rs, ft} = {abort_insn, restore_ea_regs, fault_type};
        end
    endtask

    task automatic wait_rerun();
        seen = 1'b0;
        for (int i = 0; i < 4 && !seen; i++) begin
            @(negedge mclk);
            seen = (rerun_start === 1'b1);
            rc = rerun_cycle;
        end
    endtask

    // fault taken at once, then type, restore and word compared
    task automatic one_fault(input bfs_cycle_t c, input bfs_ctx_t x,
        input logic [1:0] t, input logic r, input logic [15:0] w);
        host.fault(c, x);
        wait_take();
        chk({29'h0, seen, ft}, {29'h1, t});
        chk({30'h0, rs, ab}, {30'h0, r, 1'b1});
        host.reg_rd(REG_FSW, rd);
        chk(rd, {16'h0, w});
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs();
        host.reg_rd(REG_FSW, rd);
        chk(rd, 32'h0);
        host.reg_wr(REG_FSW, 32'h0000_ffff);
        host.reg_rd(REG_FSW, rd);
        chk(rd, 32'h0000_dfff);
        host.reg_rd(4'h9, rd);
        chk(rd, 32'h0);
        $display("test regs done");
    endtask

    // flags: rd pf at rel exc mv refetch long
    task automatic t_restartable();
        one_fault(mk(8'hc1, SIZE_WORD, 3'h6), mx(3'h6), FT_OTHER, 1'b1,
            16'h08f6);
        one_fault(mk(8'h20, SIZE_BYTE, 3'h5), mx(3'h1), FT_OTHER, 1'b1,
            16'h050d);
        $display("test restartable done");
    endtask

    task automatic t_move_exc();
        one_fault(mk(8'h85, SIZE_LONG, 3'h1), mx(3'h4), FT_MOVE, 1'b0,
            16'h5061);
        one_fault(mk(8'h88, SIZE_WORD, 3'h5), mx(3'h4), FT_EXCEPTION,
            1'b0, 16'h9055);
        host.fault(mk(8'hc2, SIZE_WORD, 3'h6), mx(3'h0));
        wait_take();
        host.reg_rd(REG_FSW, rd);
        chk(rd & 32'h4080, 32'h4080);
        $display("test move exception done");
    endtask

    task automatic t_released();
        host.fault(mk(8'h11, SIZE_WORD, 3'h5), mx(3'h0));
        wait_take();
        chk({31'h0, seen}, 32'h0);
        host.reg_rd(REG_STAT, rd);
        chk(rd, {29'h0, FT_OTHER, 1'b1});
        host.strobe(0, mx(3'h4));
        wait_take();
        chk({28'h0, seen, ab, ft}, {28'h0, 2'h2, FT_RELEASED});
        host.reg_rd(REG_FSW, rd);
        chk(rd, 32'h0000_1235);
        host.reg_rd(REG_PC, rd);
        chk(rd, 32'h0000_0100);
        host.reg_rd(REG_SR, rd);
        chk(rd, 32'h0000_2700);
        host.reg_rd(REG_ADDR, rd);
        chk(rd, 32'h1234_5678);
        host.reg_rd(REG_DATA, rd);
        chk(rd, 32'hcafe_0001);
        host.strobe(2, '0);
        wait_rerun();
        chk({31'h0, seen}, 32'h1);
        chk({26'h0, rc[69:64]}, {26'h0, 1'b0, SIZE_WORD, 3'h5});
        chk(rc.addr, 32'h1234_5678);
        chk(rc.wdata, 32'hcafe_0001);
        $display("test released done");
    endtask

    task automatic t_abort();
        host.fault(mk(8'h10, SIZE_LONG, 3'h3), mx(3'h0));
        host.strobe(1, mx(3'h0));
        wait_take();
        chk({30'h0, seen, ab}, 32'h3);
        host.reg_rd(REG_FSW, rd);
        chk(rd, 32'h0000_0203);
        host.handler_done();
        wait_rerun();
        chk({31'h0, seen}, 32'h0);
        $display("test abort done");
    endtask

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        t_regs();
        t_restartable();
        t_move_exc();
        t_released();
        t_abort();
        conclude();
    end
endmodule
